// >>> src/rcs_pkg.sv
// Package of constants and types for the reset cause status block
package rcs_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] RCS_OFF_STATUS = 8'h00;
  localparam logic [7:0] RCS_OFF_IRQ_STAT = 8'h04;
  localparam logic [7:0] RCS_OFF_IRQ_MASK = 8'h08;
  localparam logic [7:0] RCS_OFF_REQ = 8'h0C;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int RCS_BIT_POR = 0;
  localparam int RCS_BIT_BOR = 1;
  localparam int RCS_BIT_IDLE = 2;
  localparam int RCS_BIT_SLEEP = 3;
  localparam int RCS_BIT_WDT = 4;
  localparam int RCS_BIT_SWR = 6;
  localparam int RCS_BIT_PIN = 7;
  localparam int RCS_BIT_VREG = 8;
  localparam int RCS_BIT_CFG = 9;
  localparam int RCS_BIT_SWREQ = 0;

  // ----------------------------------------
  // Masks and reset values
  // ----------------------------------------
  localparam logic [9:0] RCS_IMPL_MASK = 10'h3DF;
  localparam logic [9:0] RCS_FLAG_MASK = 10'h2DF;
  localparam logic [9:0] RCS_STATUS_RST = 10'h003;
  localparam logic [9:0] RCS_IRQ_RST = 10'h000;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic cfg_mismatch;
    logic brownout;
    logic watchdog;
    logic software;
    logic wake_sleep;
    logic wake_idle;
  } rcs_events_t;

  typedef struct packed {
    logic [7:0] addr;
    logic write;
  } rcs_bus_req_t;

endpackage : rcs_pkg

// >>> src/rcs_reset_cause.sv
// Reset cause status register with AHB-Lite slave and interrupt
//
// Behaviour
// RL1 - Low master reset pin resets device
// RL2 - Pin reset sets bit 7
// RL3 - Software reset sets bit 6
// RL4 - Watchdog timeout sets bit 4
// RL5 - Wake from sleep sets bit 3
// RL6 - Wake from idle sets bit 2
// RL7 - Brown-out reset sets bit 1
// RL8 - Power-on reset sets bit 0
// RL9 - Configuration mismatch reset sets bit 9
// RL10 - Bit 8 keeps regulator on in sleep
// RL11 - Power-on: bits 1,0 one, others zero
// RL12 - Software clears brown-out, power-on flags itself
// RL13 - Bits 31-10 and 5 read zero
// RL14 - Hardware set wins over software write
// RL15 - Flags hold until software writes them
`timescale 1ns/1ps
module rcs_reset_cause (
  // Clock and power-on reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Reset and wake sources
  input wire logic master_reset_pin_n,
  input wire rcs_pkg::rcs_events_t events,
  // Outputs
  output logic system_reset_req,
  output logic regulator_standby_on,
  output logic irq
);

  // ----------------------------------------
  // Bus address phase capture
  // ----------------------------------------
  rcs_pkg::rcs_bus_req_t req_q;
  rcs_pkg::rcs_bus_req_t req_d;
  logic wr_pend_q;
  wire logic access = hsel & hready & htrans[1];

  assign req_d.addr = haddr[7:0];
  assign req_d.write = hwrite;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q <= '0;
      wr_pend_q <= 1'b0;
    end else begin
      if (access) begin
        req_q <= req_d;
      end
      wr_pend_q <= access & hwrite;
    end
  end

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  wire logic wr_status = wr_pend_q & (req_q.addr == rcs_pkg::RCS_OFF_STATUS);
  wire logic wr_istat = wr_pend_q & (req_q.addr == rcs_pkg::RCS_OFF_IRQ_STAT);
  wire logic wr_imask = wr_pend_q & (req_q.addr == rcs_pkg::RCS_OFF_IRQ_MASK);
  wire logic wr_req = wr_pend_q & (req_q.addr == rcs_pkg::RCS_OFF_REQ);

  // ----------------------------------------
  // Pin reset detection
  // ----------------------------------------
  logic pin_q;
  logic pin_low_q;
  logic sw_req_q;

  // Pin level sampled once per clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_q <= 1'b1;
    end else begin
      pin_q <= master_reset_pin_n;
    end
  end

  // Sampled level delayed by one clock to find the release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_low_q <= 1'b0;
    end else begin
      pin_low_q <= ~pin_q;
    end
  end

  // Release of the pin ends the pin reset
  wire logic pin_release = pin_low_q & pin_q;

  // Device held in reset while pin low
  assign system_reset_req = ~pin_q | sw_req_q; // see RL1

  // ----------------------------------------
  // Software reset request
  // ----------------------------------------
  wire logic sw_req_d = wr_req & hwdata[rcs_pkg::RCS_BIT_SWREQ];

  // One-cycle request pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_req_q <= 1'b0;
    end else begin
      sw_req_q <= sw_req_d;
    end
  end

  // ----------------------------------------
  // Hardware set sources
  // ----------------------------------------
  // Power-on only recorded through the reset value
  wire logic set_por = 1'b0;

  // Brown-out reset
  wire logic set_bor = events.brownout;

  // Wake from idle
  wire logic set_idle = events.wake_idle;

  // Wake from sleep
  wire logic set_sleep = events.wake_sleep;

  // Watchdog time-out
  wire logic set_wdt = events.watchdog;

  // Software reset, from the core or from this register
  wire logic set_swr = events.software | sw_req_q;

  // Pin reset, recorded at release so it survives the reset
  wire logic set_pin = pin_release;

  // Configuration mismatch reset
  wire logic set_cfg = events.cfg_mismatch;

  logic [9:0] hw_set;

  assign hw_set[rcs_pkg::RCS_BIT_POR] = set_por;
  assign hw_set[rcs_pkg::RCS_BIT_BOR] = set_bor; // see RL7
  assign hw_set[rcs_pkg::RCS_BIT_IDLE] = set_idle; // see RL6
  assign hw_set[rcs_pkg::RCS_BIT_SLEEP] = set_sleep; // see RL5
  assign hw_set[rcs_pkg::RCS_BIT_WDT] = set_wdt; // see RL4
  assign hw_set[5] = 1'b0;
  assign hw_set[rcs_pkg::RCS_BIT_SWR] = set_swr; // see RL3
  assign hw_set[rcs_pkg::RCS_BIT_PIN] = set_pin; // see RL2
  assign hw_set[rcs_pkg::RCS_BIT_VREG] = 1'b0;
  assign hw_set[rcs_pkg::RCS_BIT_CFG] = set_cfg; // see RL9

  // ----------------------------------------
  // Per-bit next state
  // ----------------------------------------
  // Status flags and regulator bit
  logic [9:0] status_q;
  logic [9:0] status_d;

  // Interrupt status
  logic [9:0] istat_q;
  logic [9:0] istat_d;

  // Interrupt mask
  logic [9:0] imask_q;
  logic [9:0] imask_d;

  // Read selects, decoded in the address phase
  wire logic rsel_status = haddr[7:0] == rcs_pkg::RCS_OFF_STATUS;
  wire logic rsel_istat = haddr[7:0] == rcs_pkg::RCS_OFF_IRQ_STAT;
  wire logic rsel_imask = haddr[7:0] == rcs_pkg::RCS_OFF_IRQ_MASK;

  logic [9:0] rd_sel;
  wire logic [9:0] wr_bits = hwdata[9:0];

  generate
    for (genvar b = 0; b < 10; b++) begin : g_bit
      wire logic impl_b = rcs_pkg::RCS_IMPL_MASK[b];
      wire logic flag_b = rcs_pkg::RCS_FLAG_MASK[b];

      // Software write then hardware set on top
      wire logic sw_b = wr_status ? wr_bits[b] : status_q[b]; // see RL15
      wire logic set_b = hw_set[b] & flag_b;

      // Flag rising this cycle raises its interrupt
      wire logic rise_b = status_d[b] & ~status_q[b] & flag_b;
      wire logic clr_b = wr_istat & wr_bits[b];

      assign status_d[b] = (sw_b | set_b) & impl_b; // see RL14 see RL13
      // New event wins over a clear in the same cycle
      assign istat_d[b] = (istat_q[b] & ~clr_b) | rise_b;
      assign imask_d[b] = wr_imask ? (wr_bits[b] & flag_b) : imask_q[b];

      // Read value from next state, so a write landing now is seen
      wire logic rd_status_b = rsel_status & status_d[b];
      wire logic rd_istat_b = rsel_istat & istat_d[b];
      wire logic rd_imask_b = rsel_imask & imask_d[b];
      assign rd_sel[b] = rd_status_b | rd_istat_b | rd_imask_b;
    end
  endgenerate

  // ----------------------------------------
  // Status register
  // ----------------------------------------
  // Power-on value of the flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q <= rcs_pkg::RCS_STATUS_RST; // see RL11 see RL8
    end else begin
      status_q <= status_d;
    end
  end

  assign regulator_standby_on = status_q[rcs_pkg::RCS_BIT_VREG]; // see RL10

  // ----------------------------------------
  // Interrupt status, mask and line
  // ----------------------------------------
  logic irq_q;
  wire logic irq_d = |(istat_d & imask_d);

  // Sticky interrupt status
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      istat_q <= rcs_pkg::RCS_IRQ_RST;
    end else begin
      istat_q <= istat_d;
    end
  end

  // Interrupt mask
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      imask_q <= rcs_pkg::RCS_IRQ_RST;
    end else begin
      imask_q <= imask_d;
    end
  end

  // Interrupt line from a flip-flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign irq = irq_q;

  // ----------------------------------------
  // Registered read data
  // ----------------------------------------
  wire logic rd_access = access & ~hwrite;
  wire logic [31:0] hrdata_d = rd_access ? {22'h00_0000, rd_sel} : 32'h0000_0000;
  logic [31:0] hrdata_q;

  // Read data stands for the data phase only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else begin
      hrdata_q <= hrdata_d;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

endmodule : rcs_reset_cause

// >>> test/rcs_reset_cause_assertions.sv
// Checker for the reset cause status block
`timescale 1ns/1ps
module rcs_reset_cause_assertions (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus and sources
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic master_reset_pin_n,
  input wire rcs_pkg::rcs_events_t events,
  // Outputs
  input wire logic system_reset_req,
  input wire logic regulator_standby_on,
  input wire logic irq
);
  logic ap_q;
  logic wr_q;
  logic [7:0] ad_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) {ap_q, wr_q, ad_q} <= '0;
    else {ap_q, wr_q, ad_q} <= {hsel && hready && htrans[1], hwrite, haddr[7:0]};
  end
  wire rd_st = ap_q && !wr_q && ad_q == rcs_pkg::RCS_OFF_STATUS;
  wire wr_st = ap_q && wr_q && ad_q == rcs_pkg::RCS_OFF_STATUS;
  wire wr_rq = ap_q && wr_q && ad_q == rcs_pkg::RCS_OFF_REQ && hwdata[0];
  wire wr_mk = ap_q && wr_q && ad_q == rcs_pkg::RCS_OFF_IRQ_MASK;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence mask_zero; wr_mk && hwdata[9:0] == 10'h0; endsequence
  sequence wdt_read; events.watchdog ##1 !wr_st [*2] ##1 rd_st; endsequence
  a_bus_ready: assert property (hreadyout) else $error("ready low");
  a_resp_okay: assert property (!hresp) else $error("error response");
  a_unimpl_zero: assert property (rd_st |-> hrdata[31:10] == 22'h0 && !hrdata[5])
    else $error("unimplemented bits set");
  a_pin_request: assert property (!master_reset_pin_n |=> system_reset_req)
    else $error("pin reset missing");
  a_sw_request: assert property (wr_rq |=> system_reset_req)
    else $error("software reset missing");
  a_no_request: assert property (master_reset_pin_n && !wr_rq |=> !system_reset_req)
    else $error("spurious reset request");
  a_standby_load: assert property (wr_st |=> regulator_standby_on == $past(hwdata[8]))
    else $error("standby bit wrong");
  a_mask_quiet: assert property (mask_zero |=> !irq) else $error("masked irq");
  a_wdt_seen: assert property (wdt_read |-> hrdata[4]) else $error("watchdog flag lost");
endmodule : rcs_reset_cause_assertions
bind rcs_reset_cause rcs_reset_cause_assertions u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .master_reset_pin_n, .events,
  .system_reset_req, .regulator_standby_on, .irq);

// >>> test/rcs_reset_cause_bench.sv
// Testbench for the reset cause status block
`timescale 1ns/1ps
module rcs_reset_cause_bench;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, pin_n = 1;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r, v;
  logic [1:0] htrans = 0;
  logic hreadyout, hresp, sreq, vreg, irq;
  rcs_pkg::rcs_events_t ev = '0;
  int err_count = 0, samples_checked = 0;
  int pos[6] = '{2, 3, 6, 4, 1, 9};
  logic [31:0] st;
  rcs_reset_cause dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(1'b1), .hrdata, .hreadyout, .hresp, .master_reset_pin_n(pin_n),
    .events(ev), .system_reset_req(sreq), .regulator_standby_on(vreg), .irq);
  initial forever #10 hclk = ~hclk;
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, 24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : xfer
  task automatic pulse(input logic [5:0] p);
    @(posedge hclk);
    ev <= p;
    @(posedge hclk);
    ev <= '0;
  endtask : pulse
  task automatic tally_and_finish;
    $display("Checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  initial begin
    #200000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    v = $urandom(32'hdd53);
    repeat (8) @(posedge hclk);
    hresetn <= 1;
    xfer(0, rcs_pkg::RCS_OFF_STATUS, 0);
    chk("status", r, 32'h3);
    chk("standby", 32'(vreg), 0);
    repeat (4) begin
      v = $urandom;
      xfer(1, rcs_pkg::RCS_OFF_STATUS, v);
      xfer(0, rcs_pkg::RCS_OFF_STATUS, 0);
      chk("status", r, v & 32'h3df);
      chk("standby", 32'(vreg), 32'(v[8]));
    end
    xfer(1, rcs_pkg::RCS_OFF_STATUS, 0);
    st = 0;
    for (int i = 0; i < 6; i++) begin
      pulse(6'h1 << i);
      st |= 32'h1 << pos[i];
      xfer(0, rcs_pkg::RCS_OFF_STATUS, 0);
      chk("flags", r, st);
    end
    xfer(1, rcs_pkg::RCS_OFF_STATUS, 0);
    pin_n <= 0;
    repeat (3) @(posedge hclk);
    chk("request", 32'(sreq), 1);
    pin_n <= 1;
    repeat (3) @(posedge hclk);
    chk("request", 32'(sreq), 0);
    xfer(0, rcs_pkg::RCS_OFF_STATUS, 0);
    chk("flags", r, 32'h80);
    xfer(1, rcs_pkg::RCS_OFF_REQ, 1);
    xfer(0, rcs_pkg::RCS_OFF_STATUS, 0);
    chk("flags", r, 32'hc0);
    xfer(0, 8'h10, 0);
    chk("unmapped", r, 0);
    xfer(1, rcs_pkg::RCS_OFF_STATUS, 0);
    xfer(1, rcs_pkg::RCS_OFF_IRQ_STAT, 32'h3ff);
    pulse(6'h08);
    xfer(0, rcs_pkg::RCS_OFF_STATUS, 0);
    chk("irq", 32'(irq), 0);
    xfer(1, rcs_pkg::RCS_OFF_IRQ_MASK, 32'h10);
    xfer(0, rcs_pkg::RCS_OFF_IRQ_STAT, 0);
    chk("irq", 32'(irq), 1);
    chk("pending", r, 32'h10);
    xfer(1, rcs_pkg::RCS_OFF_IRQ_STAT, 32'h10);
    xfer(1, rcs_pkg::RCS_OFF_IRQ_MASK, 0);
    chk("irq", 32'(irq), 0);
    tally_and_finish();
  end
endmodule : rcs_reset_cause_bench
